// ### src/rss_regs.svh
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH

// ==========================================================================
// register map
`define RSS_ADDR_STATUS   4'h0
`define RSS_ADDR_SLEEP    4'h1
`define RSS_ADDR_ANALOG   4'h2
`define RSS_ADDR_STRETCH  4'h3
// status/control register fields
`define RSS_BIT_POR       0
`define RSS_BIT_PIN       1
`define RSS_BIT_BOD       2
`define RSS_BIT_WDT       3
`define RSS_BIT_SCAN      4
`define RSS_BIT_TPD       7
// sleep register: bit 3 asleep, bits 2..0 mode
`define RSS_BIT_ASLEEP    3
// analog register fields
`define RSS_BIT_ADC_EN    0
`define RSS_BIT_ACMP_EN   1
`define RSS_BIT_ACMP_REF  2
`define RSS_BIT_WDT_EN    3
`define RSS_STATUS_RST    8'h01
// ==========================================================================
// timing
`define RSS_CLK_NS        10
`define RSS_PIN_MIN_NS    1500
`define RSS_PIN_CYC       ((`RSS_PIN_MIN_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
`define RSS_BOD_MIN_NS    2000
`define RSS_BOD_CYC       ((`RSS_BOD_MIN_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
`define RSS_HYST_MV       100
`define RSS_BOT_LOW_MV    2700
`define RSS_BOT_HIGH_MV   4000
// base stretch length in clk_sys cycles, scaled up by the clock-select code
`define RSS_STRETCH_BASE  16
`endif

// ### src/rss_pkg.sv
package rss_pkg;
    // sleep modes as coded by the mode field
    typedef enum logic [2:0] {
        RSS_SLP_IDLE    = 3'b000,
        RSS_SLP_ADCNR   = 3'b001,
        RSS_SLP_PDOWN   = 3'b010,
        RSS_SLP_PSAVE   = 3'b011,
        RSS_SLP_RSV4    = 3'b100,
        RSS_SLP_RSV5    = 3'b101,
        RSS_SLP_STBY    = 3'b110,
        RSS_SLP_XSTBY   = 3'b111
    } rss_sleep_e;

    // fuse set, sampled as plain levels
    typedef struct packed {
        logic       brownout_enable_fuse;
        logic       brownout_level_fuse;
        logic       debug_enable_fuse;
        logic       test_port_enable_fuse;
        logic [3:0] clock_select_fuses;
    } rss_fuse_s;

    // power-management outputs
    typedef struct packed {
        logic main_clk_keep;
        logic input_buf_en;
        logic adc_en;
        logic adc_extended;
        logic acmp_en;
        logic vref_en;
        logic wdt_run;
        logic test_port_en;
    } rss_power_s;
endpackage

// ### src/rss_top.sv
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rss_regs.svh"

module rss_top (
    input  wire logic               clk_sys,
    input  wire logic               reset_n,
    input  wire logic               power_ok,
    input  wire logic               reset_pin_n,
    input  wire logic               wdt_expire,
    input  wire logic [12:0]        supply_mv,
    input  wire logic               scan_reset_bit,
    input  wire rss_pkg::rss_fuse_s fuses,
    input  wire logic               wake_pin_req,
    input  wire logic               tap_shifting,
    input  wire logic               tdo_data,
    input  wire logic [3:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [7:0]              reg_rdata,
    output logic                    port_reset_n,
    output logic                    core_reset_n,
    output logic                    fetch_vector,
    output logic                    wdt_reset_pulse,
    output logic                    tdo_out,
    output logic                    tdo_oe,
    output rss_pkg::rss_power_s     power
);
    import rss_pkg::*;

    typedef enum logic [1:0] {
        RSS_ST_HOLD    = 2'b00,
        RSS_ST_STRETCH = 2'b01,
        RSS_ST_RUN     = 2'b10
    } rss_state_e;

    // ======================================================================
    // source conditioning
    logic [7:0]  pin_cnt_ff;
    logic        pin_rst_ff;
    logic [7:0]  bod_cnt_ff;
    logic        bod_rst_ff;
    logic        bod_below_ff;
    logic        wdt_pulse_ff;
    logic        wdt_en_ff;
    logic [12:0] bot_mv;
    logic        any_src;

    // trigger level picked by level fuse, hysteresis split evenly
    assign bot_mv = fuses.brownout_level_fuse ? 13'(`RSS_BOT_HIGH_MV)
                                              : 13'(`RSS_BOT_LOW_MV);

    // comparator with hysteresis: trip below low edge, clear above high edge
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bod_below_ff <= 1'b0;
        end else if (supply_mv < bot_mv - 13'(`RSS_HYST_MV / 2)) begin
            bod_below_ff <= 1'b1;
        end else if (supply_mv > bot_mv + 13'(`RSS_HYST_MV / 2)) begin
            bod_below_ff <= 1'b0;
        end
    end

    // dip must persist past minimum period before reset asserts
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bod_cnt_ff <= 8'h00;
            bod_rst_ff <= 1'b0;
        end else if (!fuses.brownout_enable_fuse || !bod_below_ff) begin
            bod_cnt_ff <= 8'h00;
            bod_rst_ff <= 1'b0;
        end else if (bod_cnt_ff < 8'(`RSS_BOD_CYC)) begin
            bod_cnt_ff <= bod_cnt_ff + 8'h01;
        end else begin
            bod_rst_ff <= 1'b1;
        end
    end

    // pin low filter; short glitches never reach the core reset
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pin_cnt_ff <= 8'h00;
            pin_rst_ff <= 1'b0;
        end else if (reset_pin_n) begin
            pin_cnt_ff <= 8'h00;
            pin_rst_ff <= 1'b0;
        end else if (pin_cnt_ff < 8'(`RSS_PIN_CYC)) begin
            pin_cnt_ff <= pin_cnt_ff + 8'h01;
        end else begin
            pin_rst_ff <= 1'b1;
        end
    end

    // watchdog pulse: one cycle wide, repeating every other cycle while expiry is held; only if enabled
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wdt_pulse_ff <= 1'b0;
        end else begin
            wdt_pulse_ff <= wdt_expire && wdt_en_ff
                            && !wdt_pulse_ff;
        end
    end
    assign wdt_reset_pulse = wdt_pulse_ff;

    // or of all five sources
    assign any_src = !power_ok || pin_rst_ff || wdt_pulse_ff
                     || bod_rst_ff || scan_reset_bit;

    // ======================================================================
    // stretch counter
    rss_state_e  state_ff;
    logic [19:0] stretch_ff;
    logic [19:0] stretch_len;

    // fuse code scales the hold time; counts of clk_sys cycles
    assign stretch_len = 20'(`RSS_STRETCH_BASE)
                         << fuses.clock_select_fuses;

    // hold while any source active; count once all have dropped
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_ff   <= RSS_ST_HOLD;
            stretch_ff <= 20'h00000;
        end else if (any_src) begin
            state_ff   <= RSS_ST_HOLD;
            stretch_ff <= 20'h00000;
        end else begin
            case (state_ff)
                RSS_ST_HOLD: begin
                    state_ff <= RSS_ST_STRETCH;
                end
                RSS_ST_STRETCH: begin
                    stretch_ff <= stretch_ff + 20'h00001;
                    if (stretch_ff + 20'h00001 >= stretch_len) begin
                        state_ff <= RSS_ST_RUN;
                    end
                end
                RSS_ST_RUN: begin
                    state_ff <= RSS_ST_RUN;
                end
                default: begin
                    state_ff <= RSS_ST_HOLD;
                end
            endcase
        end
    end

    // core reset from flop; fetch pulse marks start at reset vector
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            core_reset_n <= 1'b0;
            fetch_vector <= 1'b0;
        end else begin
            core_reset_n <= (state_ff == RSS_ST_RUN) && !any_src;
            fetch_vector <= (state_ff == RSS_ST_RUN) && !any_src
                            && !core_reset_n;
        end
    end

    // port reset: flop is cleared asynchronously by power loss or a low reset pin, so no
    // clock edge is needed to force ports to their initial state
    logic src_async_n;
    assign src_async_n = reset_n && power_ok && reset_pin_n;
    always_ff @(posedge clk_sys or negedge src_async_n) begin
        if (!src_async_n) begin
            port_reset_n <= 1'b0;
        end else begin
            port_reset_n <= !any_src;
        end
    end

    // ======================================================================
    // registers
    logic [7:0] status_ff;
    logic [3:0] sleep_ff;
    logic       adc_en_ff;
    logic       adc_was_off_ff;
    logic       acmp_en_ff;
    logic       acmp_ref_ff;
    logic       wr_status;
    logic       wr_analog;

    assign wr_status = reg_wr && reg_addr == `RSS_ADDR_STATUS;
    assign wr_analog = reg_wr && reg_addr == `RSS_ADDR_ANALOG;

    // flags: source sets win over software clears; por clears all but itself and the tpd bit
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            status_ff <= `RSS_STATUS_RST;
        end else if (!power_ok) begin
            status_ff <= `RSS_STATUS_RST | (status_ff & 8'h80);
        end else begin
            if (wr_status) begin
                status_ff[`RSS_BIT_SCAN:`RSS_BIT_POR] <=
                    status_ff[`RSS_BIT_SCAN:`RSS_BIT_POR] & reg_wdata[4:0];
                status_ff[`RSS_BIT_TPD] <= reg_wdata[`RSS_BIT_TPD];
            end
            if (pin_rst_ff) status_ff[`RSS_BIT_PIN] <= 1'b1;
            if (bod_rst_ff) status_ff[`RSS_BIT_BOD] <= 1'b1;
            if (wdt_pulse_ff) status_ff[`RSS_BIT_WDT] <= 1'b1;
            if (scan_reset_bit) status_ff[`RSS_BIT_SCAN] <= 1'b1;
        end
    end

    // sleep and analog controls; all but the watchdog enable cleared by core reset
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sleep_ff       <= 4'h0;
            adc_en_ff      <= 1'b0;
            acmp_en_ff     <= 1'b0;
            acmp_ref_ff    <= 1'b0;
            wdt_en_ff      <= 1'b0;
            adc_was_off_ff <= 1'b1;
        end else if (!core_reset_n) begin
            sleep_ff       <= 4'h0;
            adc_en_ff      <= 1'b0;
            acmp_en_ff     <= 1'b0;
            acmp_ref_ff    <= 1'b0;
            wdt_en_ff      <= wdt_en_ff;
            adc_was_off_ff <= 1'b1;
        end else begin
            if (reg_wr && reg_addr == `RSS_ADDR_SLEEP) begin
                sleep_ff <= reg_wdata[3:0];
            end
            if (wr_analog) begin
                adc_en_ff   <= reg_wdata[`RSS_BIT_ADC_EN];
                acmp_en_ff  <= reg_wdata[`RSS_BIT_ACMP_EN];
                acmp_ref_ff <= reg_wdata[`RSS_BIT_ACMP_REF];
                wdt_en_ff   <= reg_wdata[`RSS_BIT_WDT_EN];
            end
            // first conversion after re-enable is extended
            if (!adc_en_ff) adc_was_off_ff <= 1'b1;
            else if (wake_pin_req || wr_analog) adc_was_off_ff <= 1'b0;
        end
    end

    // ======================================================================
    // power gating, all outputs registered
    rss_sleep_e mode;
    logic       asleep;
    logic       deep;
    logic       acmp_live;
    assign mode   = rss_sleep_e'(sleep_ff[2:0]);
    assign asleep = sleep_ff[`RSS_BIT_ASLEEP];
    assign deep   = asleep && mode != RSS_SLP_IDLE && mode != RSS_SLP_ADCNR;
    assign acmp_live = acmp_en_ff && !deep;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            power <= '0;
        end else begin
            power.main_clk_keep <= fuses.debug_enable_fuse && asleep
                && (mode == RSS_SLP_PDOWN || mode == RSS_SLP_PSAVE);
            power.input_buf_en  <= !deep || wake_pin_req;
            power.adc_en        <= adc_en_ff;
            power.adc_extended  <= adc_en_ff && adc_was_off_ff;
            power.acmp_en       <= acmp_live;
            power.vref_en       <= fuses.brownout_enable_fuse || adc_en_ff
                                   || (acmp_en_ff && acmp_ref_ff);
            power.wdt_run       <= wdt_en_ff;
            power.test_port_en  <= fuses.test_port_enable_fuse
                                   && !status_ff[`RSS_BIT_TPD];
        end
    end

    // test data out driven only while shifting
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tdo_out <= 1'b0;
            tdo_oe  <= 1'b0;
        end else begin
            tdo_out <= tdo_data;
            tdo_oe  <= power.test_port_en && tap_shifting;
        end
    end

    // read port, data one cycle later; unmapped reads zero
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `RSS_ADDR_STATUS:  reg_rdata <= status_ff;
                `RSS_ADDR_SLEEP:   reg_rdata <= {4'h0, sleep_ff};
                `RSS_ADDR_ANALOG:  reg_rdata <= {4'h0, wdt_en_ff, acmp_ref_ff,
                                                 acmp_en_ff, adc_en_ff};
                `RSS_ADDR_STRETCH: reg_rdata <= {6'h00, state_ff};
                default:           reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule

`default_nettype wire

// ### dv/rss_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// port-side checks of the reset sequencer
module rss_checker (
    input wire logic                clk_sys,
    input wire logic                reset_n,
    input wire logic                power_ok,
    input wire logic                reset_pin_n,
    input wire logic                scan_reset_bit,
    input wire logic                wdt_expire,
    input wire logic                tap_shifting,
    input wire rss_pkg::rss_fuse_s  fuses,
    input wire logic                port_reset_n,
    input wire logic                core_reset_n,
    input wire logic                fetch_vector,
    input wire logic                wdt_reset_pulse,
    input wire logic                tdo_oe,
    input wire rss_pkg::rss_power_s power
);
    import rss_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic [19:0] quiet_ff;
    // quiet cycles while core is held; only an upper bound, since the
    // filtered brown-out source is not visible here
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            quiet_ff <= 20'h0;
        end else if (core_reset_n || !power_ok || !reset_pin_n
                     || scan_reset_bit || wdt_reset_pulse) begin
            quiet_ff <= 20'h0;
        end else if (quiet_ff != 20'hfffff) begin
            quiet_ff <= quiet_ff + 20'h1;
        end
    end
    port_async_a: assert property (
        !power_ok || !reset_pin_n |-> !port_reset_n)
        else $error("port reset not immediate");
    por_hold_a: assert property (
        !power_ok |=> !core_reset_n)
        else $error("core left reset during power loss");
    scan_hold_a: assert property (
        scan_reset_bit [*2] |-> !core_reset_n)
        else $error("core left reset while scan bit set");
    wdt_width_a: assert property (
        wdt_reset_pulse |=> !wdt_reset_pulse)
        else $error("watchdog pulse longer than one cycle");
    wdt_cause_a: assert property (
        $rose(wdt_reset_pulse) |-> $past(wdt_expire))
        else $error("watchdog pulse without expiry");
    stretch_min_a: assert property (
        $rose(core_reset_n) |->
        quiet_ff + 20'h1 >= (20'h10 << fuses.clock_select_fuses))
        else $error("reset stretch too short");
    fetch_rel_a: assert property (
        $rose(core_reset_n) |-> ##[0:1] fetch_vector)
        else $error("no vector fetch at release");
    tdo_idle_a: assert property (
        !tap_shifting [*2] |-> !tdo_oe)
        else $error("test output driven while idle");
    tport_off_a: assert property (
        !fuses.test_port_enable_fuse [*2] |-> !power.test_port_en)
        else $error("test port on with fuse clear");
    cover property ($rose(wdt_reset_pulse));
    cover property ($fell(core_reset_n) && power_ok && reset_pin_n);
    cover property ($rose(core_reset_n));
endmodule
bind rss_top rss_checker u_chk (.clk_sys, .reset_n, .power_ok,
    .reset_pin_n, .scan_reset_bit, .wdt_expire, .tap_shifting, .fuses,
    .port_reset_n, .core_reset_n, .fetch_vector, .wdt_reset_pulse,
    .tdo_oe, .power);
`default_nettype wire

// ### dv/rss_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// far side: supply monitor, reset pin, watchdog, scan register
module rss_src_model (
    input  wire logic        clk_sys,
    input  wire logic        go,
    input  wire logic [2:0]  kind,
    input  wire logic [9:0]  len,
    input  wire logic [12:0] low_mv,
    output logic             busy,
    output logic             power_ok,
    output logic             reset_pin_n,
    output logic             wdt_expire,
    output logic [12:0]      supply_mv,
    output logic             scan_reset_bit
);
    logic [9:0] cnt_ff = 10'h0;
    logic [2:0] kind_ff = 3'h0;
    // one event at a time, held for len cycles
    always_ff @(posedge clk_sys) begin
        if (go && !busy) begin
            cnt_ff  <= len;
            kind_ff <= kind;
        end else if (busy) begin
            cnt_ff <= cnt_ff - 10'h1;
        end
    end
    assign busy = cnt_ff != 10'h0;
    // each source moves only its own line
    assign power_ok       = !(busy && kind_ff == 3'h0);
    assign reset_pin_n    = !(busy && kind_ff == 3'h1); // pulled up
    assign supply_mv      = (busy && kind_ff == 3'h2) ? low_mv : 13'hce4;
    assign wdt_expire     = busy && kind_ff == 3'h3;
    assign scan_reset_bit = busy && kind_ff == 3'h4;
endmodule
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rss_regs.svh"
module tb_top;
    import rss_pkg::*;
    logic        clk_sys, reset_n, reg_wr, reg_rd, go, busy;
    logic        wake_pin_req, tap_shifting, tdo_data, wdt_reset_pulse;
    logic        power_ok, reset_pin_n, wdt_expire, scan_reset_bit;
    logic        port_reset_n, core_reset_n, fetch_vector, tdo_out, tdo_oe;
    logic [2:0]  kind;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, d, exp_st;
    logic [9:0]  len;
    logic [12:0] low_mv, supply_mv;
    logic [31:0] seed;
    rss_fuse_s   fuses;
    rss_power_s  power;
    int          miscompares, num_checks, pulses, n;
    int          ks[5] = '{1, 0, 2, 3, 4};
    int          ls[5] = '{200, 10, 250, 1, 20};
    rss_top uut (.clk_sys, .reset_n, .power_ok, .reset_pin_n, .wdt_expire,
        .supply_mv, .scan_reset_bit, .fuses, .wake_pin_req, .tap_shifting,
        .tdo_data, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .port_reset_n, .core_reset_n, .fetch_vector, .wdt_reset_pulse,
        .tdo_out, .tdo_oe, .power);
    rss_src_model src_m (.clk_sys, .go, .kind, .len, .low_mv, .busy,
        .power_ok, .reset_pin_n, .wdt_expire, .supply_mv, .scan_reset_bit);
    // ==========
    // clock and pulse counter
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (wdt_reset_pulse === 1'b1) pulses++;
    // ==========
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // flags accumulate; power loss leaves only its own flag
    function automatic logic [7:0] exp_status(input logic [7:0] p,
                                              input int k);
        return (k == 0) ? 8'h01 : (p | (8'h01 << k));
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic nap(input int c);
        repeat (c) @(negedge clk_sys);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
    task automatic src(input int k, input int l, input logic [12:0] mv);
        @(posedge clk_sys);
        go     <= 1'b1;
        kind   <= 3'(k);
        len    <= 10'(l);
        low_mv <= mv;
        @(posedge clk_sys);
        go <= 1'b0;
    endtask
    task automatic fz(input logic e, input logic l, input logic t);
        @(posedge clk_sys);
        fuses.brownout_enable_fuse  <= e;
        fuses.brownout_level_fuse   <= l;
        fuses.test_port_enable_fuse <= t;
    endtask
    // bounded wait for the core reset to reach a level
    task automatic wait_core(input logic lvl, input int lim);
        for (n = 0; core_reset_n !== lvl; n++) begin
            @(negedge clk_sys);
            if (n == lim) begin
                miscompares++;
                $display("ERROR t=%0t core=%h exp=%h", $time,
                         core_reset_n, lvl);
                end_of_test();
            end
        end
    endtask
    // ==========
    // main sequence
    initial begin
        reset_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        go = 1'b0;
        kind = 3'h0;
        len = 10'h0;
        low_mv = 13'h0;
        reg_addr = 4'h0;
        reg_wdata = 8'h0;
        wake_pin_req = 1'b0;
        tap_shifting = 1'b0;
        tdo_data = 1'b0;
        fuses = '{1'b1, 1'b0, 1'b0, 1'b1, 4'h0};
        seed = 32'h7e05645f;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        wait_core(1'b1, 100);
        chk(n >= 18 && n <= 20, 1);
        rd(`RSS_ADDR_STATUS);
        chk(d, `RSS_STATUS_RST);
        chk(power.test_port_en, 1);
        wr(`RSS_ADDR_STATUS, 8'h00);
        rd(`RSS_ADDR_STATUS);
        chk(d, 0);
        rd(4'hf);
        chk(d, 0);
        done("release");
        // short glitches and a disabled watchdog must not reset
        wr(`RSS_ADDR_ANALOG, 8'h00);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            seed = xs(seed);
            tap_shifting <= seed[8];
            tdo_data <= seed[9];
            src(1 + seed[1:0] % 3, 1 + seed[15:8] % 140,
                13'(2000 + seed[23:16]));
            nap(160);
            chk(core_reset_n, 1);
            chk({tdo_oe, tdo_out}, {tap_shifting, tdo_data});
        end
        rd(`RSS_ADDR_STATUS);
        chk(d, 0);
        chk(pulses, 0);
        done("glitch");
        fz(1'b0, 1'b0, 1'b1);
        src(2, 300, 13'ha28);
        nap(330);
        chk(core_reset_n, 1);
        fz(1'b1, 1'b0, 1'b1);
        done("bod_off");
        exp_st = 8'h00;
        for (int i = 0; i < 5; i++) begin
            if (ks[i] == 3) wr(`RSS_ADDR_ANALOG, 8'h08);
            src(ks[i], ls[i], 13'ha28);
            wait_core(1'b0, 400);
            wait_core(1'b1, 600);
            exp_st = exp_status(exp_st, ks[i]);
            rd(`RSS_ADDR_STATUS);
            chk(d, exp_st);
        end
        chk(pulses, 1);
        done("sources");
        fz(1'b1, 1'b1, 1'b1);
        wait_core(1'b0, 400);
        fz(1'b1, 1'b0, 1'b1);
        wait_core(1'b1, 600);
        rd(`RSS_ADDR_STATUS);
        chk(d[`RSS_BIT_BOD], 1);
        done("level");
        // doubled stretch: core fall to core release is len + stretch + 1
        @(posedge clk_sys);
        fuses.clock_select_fuses <= 4'h1;
        src(4, 20, 13'ha28);
        wait_core(1'b0, 400);
        wait_core(1'b1, 600);
        chk(n, 21 + (`RSS_STRETCH_BASE << 1));
        @(posedge clk_sys);
        fuses.clock_select_fuses <= 4'h0;
        fuses.debug_enable_fuse  <= 1'b1;
        done("stretch");
        wr(`RSS_ADDR_ANALOG, 8'h0b);
        for (int m = 0; m < 8; m++) begin
            if (m == 4 || m == 5) continue;
            wr(`RSS_ADDR_SLEEP, 8'(8 + m));
            nap(3);
            chk(power.acmp_en, m < 2);
            chk(power.input_buf_en, m < 2);
            chk(power.adc_en, 1);
            chk(power.vref_en, 1);
            chk(power.main_clk_keep, m == 2 || m == 3);
            chk(power.adc_extended, 1);
            chk(power.wdt_run, 1);
        end
        wr(`RSS_ADDR_SLEEP, 8'h00);
        fz(1'b0, 1'b0, 1'b1);
        wr(`RSS_ADDR_ANALOG, 8'h00);
        nap(3);
        chk(power.vref_en, 0);
        done("sleep");
        wr(`RSS_ADDR_STATUS, 8'h80);
        nap(3);
        chk(power.test_port_en, 0);
        fz(1'b0, 1'b0, 1'b0);
        nap(4);
        done("test_port");
        end_of_test();
    end
endmodule
`default_nettype wire
